/* File: verilog/ees_pkg.sv */
//----------------------------------------------------------------------
// Purpose : Shared constants and types of the serial EEPROM slave
// Assumes : 125 MHz system clock
// Notes   : Timing counts are derived from times in their own unit
//----------------------------------------------------------------------
package ees_pkg;

   //-------------------------------------------------------------------
   // Protocol constants
   //-------------------------------------------------------------------
   localparam logic [3:0] CTRL_ARRAY    = 4'ha;  // Normal array access
   localparam logic [3:0] CTRL_LOCK     = 4'h6;  // Protection register
   localparam logic [3:0] BITS_PER_WORD = 4'h8;
   localparam logic [3:0] CNT_ZERO      = 4'h0;
   localparam logic [3:0] CNT_ONE       = 4'h1;
   localparam logic [7:0] ADDR_ONE      = 8'h01;
   localparam logic [7:0] ADDR_RST      = 8'h00;
   localparam logic [7:0] DUMMY_DATA    = 8'hff; // Status read filler
   localparam int         PAGE_BYTES    = 16;
   localparam int         MEM_BYTES     = 256;
   localparam int         PROT_BIT      = 7;     // Clear in 00h-7fh
   localparam int         FIFO_W        = 12;    // Page index + byte

   //-------------------------------------------------------------------
   // Pin synchroniser layout: 0 scl, 1 sda, 2 protect, 5:3 straps
   //-------------------------------------------------------------------
   localparam logic [5:0] SYNC_RST      = 6'h03; // Bus lines idle high

   //-------------------------------------------------------------------
   // Timing
   //-------------------------------------------------------------------
   localparam int NV_WRITE_TIME_US  = 10000;
   localparam int CLK_FREQ_MHZ      = 125;
   localparam int NV_WRITE_CYCLES   = NV_WRITE_TIME_US * CLK_FREQ_MHZ;

   //-------------------------------------------------------------------
   // Protocol states
   //-------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_DEV   = 3'b001,
      ST_WADDR = 3'b010,
      ST_WDATA = 3'b011,
      ST_RDATA = 3'b100
   } ees_state_t;

endpackage

/* File: verilog/ees_fifo2.sv */
//----------------------------------------------------------------------
// Purpose : Two-entry valid/ready buffer for received write bytes
// Assumes : Both sides on sys_clk_i
// Notes   : Full and empty are exact; a stalled drain fills it
//----------------------------------------------------------------------
`timescale 1ns/100ps

module ees_fifo2 #(
   parameter int W = 12
) (
   input  wire logic         sys_clk_i,
   input  wire logic         rst_i,
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic [W-1:0]      out_data_o
);

   logic [W-1:0] slot_r [2];
   logic         wr_ptr_r;
   logic         rd_ptr_r;
   logic [1:0]   fill_r;
   logic         push;
   logic         pop;

   // Handshakes come straight from the fill count
   assign in_ready_o  = (fill_r != 2'h2);
   assign out_valid_o = (fill_r != 2'h0);
   assign out_data_o  = slot_r[rd_ptr_r];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // Storage is written only on an accepted push
   always_ff @(posedge sys_clk_i)
   begin
      if (push)
         slot_r[wr_ptr_r] <= in_data_i;
   end

   // Pointers and fill level
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         fill_r   <= 2'h0;
      end
      else
      begin
         wr_ptr_r <= wr_ptr_r ^ push;
         rd_ptr_r <= rd_ptr_r ^ pop;
         fill_r   <= fill_r + {1'b0, push} - {1'b0, pop};
      end
   end

   property p_no_overflow;
      @(posedge sys_clk_i) disable iff (rst_i)
      (fill_r == 2'h2) && !pop |=> (fill_r == 2'h2);
   endproperty
   a_no_overflow: assert property (p_no_overflow)
      else $error("buffer lost or gained an entry while full");

endmodule

/* File: verilog/ees_eeprom_slave.sv */
//----------------------------------------------------------------------
// Purpose : Two-wire slave of a 256-byte EEPROM with write protection
// Assumes : SCL, SDA, protect and strap pins are asynchronous inputs
// Notes   : Array and lock are nonvolatile: rst_i does not touch them
//----------------------------------------------------------------------
`timescale 1ns/100ps

// Behaviour
// - SDA changing while SCL high is start or stop, never data
// - SDA falling with SCL high is a start, detected at any time
// - SDA rising with SCL high is a stop; stop returns to standby
// - Words are eight bits MSB first; receiver acks low on ninth clock
// - Standby at power-up and after stop once internal work ends
// - First word top nibble 1010 selects array, 0110 the lock
// - Address bits three to one must equal the three strap pins
// - Address word LSB one means read, zero means write
// - Match is acked; mismatch is not acked and waits for a start
// - Lock programmed: control code 0110 is never acked
// - Byte write acks address and data; stop starts timed write
// - During the timed write all bus input is ignored and unacked
// - Writes to protected bytes are acked but leave the array
// - Page write takes up to sixteen bytes, each acked, ended by stop
// - Only the low four address bits count, wrapping inside the page
// - Ack polling: address word acked only after write completes
// - Lock permanently blocks writes to 00h-7fh and never clears
// - Lock set by a 0110 write with protect low; contents ignored
// - Protect high blocks whole array and lock programming
// - Protect low: lock set allows 80h-ffh only, else all writable
// - Status read of 0110 acked with filler if unlocked, else no ack
// - Address counter holds last address plus one between operations
module ees_eeprom_slave #(
   parameter int unsigned WR_CYCLES = ees_pkg::NV_WRITE_CYCLES
) (
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_o,
   output logic      sda_oe_n_o,
   input  wire logic chip_select_bit2_i,
   input  wire logic chip_select_bit1_i,
   input  wire logic chip_select_bit0_i,
   input  wire logic wp_i,
   output logic      standby_o
);

   localparam int TW = $clog2(WR_CYCLES + 1);

   //-------------------------------------------------------------------
   // Declarations
   //-------------------------------------------------------------------
   logic [5:0]          meta_r;
   logic [5:0]          sync_r;
   logic                scl_d_r;
   logic                sda_d_r;
   ees_pkg::ees_state_t state_r;
   logic [3:0]          cnt_r;
   logic                ninth_r;
   logic                ack_r;
   logic                mack_r;
   logic [7:0]          rx_r;
   logic [7:0]          tx_r;
   logic [7:0]          addr_r;
   logic                lockcmd_r;
   logic                pend_r;
   logic                busy_r;
   logic [TW-1:0]       tmr_r;
   logic [3:0]          row_r;
   logic                cmd_lock_r;
   logic                lock_r = 1'b0;
   logic [7:0]          mem_r  [ees_pkg::MEM_BYTES];
   logic [7:0]          page_r [ees_pkg::PAGE_BYTES];
   logic [15:0]         pvalid_r;
   logic                standby_r;

   //-------------------------------------------------------------------
   // Decoding helpers
   //-------------------------------------------------------------------
   // Address word acceptance; busy refuses everything so polls see nack
   function automatic logic dev_ack(input logic [7:0] w,
                                    input logic [2:0] cs,
                                    input logic       lock,
                                    input logic       busy);
      logic hit;
      hit     = (w[3:1] == cs) && !busy;
      dev_ack = hit && ((w[7:4] == ees_pkg::CTRL_ARRAY) ||
                        ((w[7:4] == ees_pkg::CTRL_LOCK) && !lock));
   endfunction

   // Whether one array byte may change under the present protection
   function automatic logic writable(input logic [7:0] a,
                                     input logic       wp,
                                     input logic       lock);
      writable = !wp && !(lock && !a[ees_pkg::PROT_BIT]);
   endfunction

   //-------------------------------------------------------------------
   // Pin synchronisers
   //-------------------------------------------------------------------
   // Two stages before any logic; edges come from the second stage only
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta_r  <= ees_pkg::SYNC_RST;
         sync_r  <= ees_pkg::SYNC_RST;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         meta_r  <= {chip_select_bit2_i, chip_select_bit1_i,
                     chip_select_bit0_i, wp_i, sda_i, scl_i};
         sync_r  <= meta_r;
         scl_d_r <= sync_r[0];
         sda_d_r <= sync_r[1];
      end
   end

   logic       scl_s;
   logic       sda_s;
   logic       wp_s;
   logic [2:0] cs_s;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic       word_done;
   logic       dev_ok;
   logic       is_lock;
   logic       push_v;
   logic       push_rdy;
   logic       pop_v;
   logic       pop_rdy;
   logic [ees_pkg::FIFO_W-1:0] pop_data;
   logic       wr_go;
   logic       wr_done;
   logic [7:0] rd_byte;

   // Bus events; data is taken only on SCL edges so SDA moves with SCL
   // high can only mean start or stop
   assign scl_s     = sync_r[0];
   assign sda_s     = sync_r[1];
   assign wp_s      = sync_r[2];
   assign cs_s      = sync_r[5:3];
   assign scl_rise  = scl_s && !scl_d_r;
   assign scl_fall  = !scl_s && scl_d_r;
   assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
   assign stop_det  = scl_s && scl_d_r && !sda_d_r && sda_s;
   assign word_done = scl_fall && (cnt_r == ees_pkg::BITS_PER_WORD) &&
                      !ninth_r;
   assign dev_ok    = dev_ack(rx_r, cs_s, lock_r, busy_r);
   assign is_lock   = (rx_r[7:4] == ees_pkg::CTRL_LOCK);
   assign push_v    = word_done && (state_r == ees_pkg::ST_WDATA);
   assign rd_byte   = lockcmd_r ? ees_pkg::DUMMY_DATA : mem_r[addr_r];

   //-------------------------------------------------------------------
   // Bit and word protocol
   //-------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r   <= ees_pkg::ST_IDLE;
         cnt_r     <= ees_pkg::CNT_ZERO;
         ninth_r   <= 1'b0;
         ack_r     <= 1'b0;
         mack_r    <= 1'b1;
         rx_r      <= ees_pkg::ADDR_RST;
         tx_r      <= ees_pkg::DUMMY_DATA;
         addr_r    <= ees_pkg::ADDR_RST;
         lockcmd_r <= 1'b0;
         pend_r    <= 1'b0;
      end
      else if (start_det)
      begin
         // A start aborts whatever was in flight, any time
         state_r   <= ees_pkg::ST_DEV;
         cnt_r     <= ees_pkg::CNT_ZERO;
         ninth_r   <= 1'b0;
         ack_r     <= 1'b0;
         lockcmd_r <= 1'b0;
         pend_r    <= 1'b0;
      end
      else if (stop_det)
      begin
         state_r <= ees_pkg::ST_IDLE;
         ninth_r <= 1'b0;
         ack_r   <= 1'b0;
         pend_r  <= 1'b0;
      end
      else if (scl_rise && state_r != ees_pkg::ST_IDLE)
      begin
         if (cnt_r != ees_pkg::BITS_PER_WORD)
         begin
            rx_r  <= {rx_r[6:0], sda_s};
            cnt_r <= cnt_r + ees_pkg::CNT_ONE;
         end
         else if (ninth_r)
            mack_r <= sda_s;
      end
      else if (scl_fall && state_r != ees_pkg::ST_IDLE)
      begin
         if (word_done)
         begin
            // Start of the ninth clock: decide and drive the ack
            ninth_r <= 1'b1;
            case (state_r)
               ees_pkg::ST_DEV:   ack_r <= dev_ok;
               ees_pkg::ST_WADDR: ack_r <= 1'b1;
               ees_pkg::ST_WDATA: ack_r <= push_rdy;
               default:           ack_r <= 1'b0;
            endcase
            if (state_r == ees_pkg::ST_WADDR && !lockcmd_r)
               addr_r <= rx_r;
            if (push_v && push_rdy)
            begin
               // Low nibble wraps inside the page, row stays put
               addr_r[3:0] <= addr_r[3:0] + ees_pkg::CNT_ONE;
               pend_r      <= 1'b1;
            end
         end
         else if (ninth_r)
         begin
            // End of the ninth clock: release and move on
            ninth_r <= 1'b0;
            ack_r   <= 1'b0;
            cnt_r   <= ees_pkg::CNT_ZERO;
            case (state_r)
               ees_pkg::ST_DEV:
               begin
                  lockcmd_r <= is_lock;
                  if (!ack_r)
                     state_r <= ees_pkg::ST_IDLE;
                  else if (rx_r[0])
                  begin
                     state_r <= ees_pkg::ST_RDATA;
                     tx_r    <= is_lock ? ees_pkg::DUMMY_DATA
                                        : mem_r[addr_r];
                     if (!is_lock)
                        addr_r <= addr_r + ees_pkg::ADDR_ONE;
                  end
                  else
                     state_r <= ees_pkg::ST_WADDR;
               end
               ees_pkg::ST_WADDR: state_r <= ees_pkg::ST_WDATA;
               ees_pkg::ST_RDATA:
               begin
                  if (mack_r)
                     state_r <= ees_pkg::ST_IDLE;
                  else
                  begin
                     tx_r <= rd_byte;
                     if (!lockcmd_r)
                        addr_r <= addr_r + ees_pkg::ADDR_ONE;
                  end
               end
               default: state_r <= state_r;
            endcase
         end
         else if (state_r == ees_pkg::ST_RDATA && cnt_r != ees_pkg::CNT_ZERO)
            tx_r <= {tx_r[6:0], 1'b1};
      end
   end

   // Open drain: only ever pull low, release otherwise
   assign sda_o      = 1'b0;
   assign sda_oe_n_o = !(ack_r || (state_r == ees_pkg::ST_RDATA &&
                                   !ninth_r && !tx_r[7]));

   //-------------------------------------------------------------------
   // Write byte buffer and page latch
   //-------------------------------------------------------------------
   ees_fifo2 #(
      .W (ees_pkg::FIFO_W)
   ) u_wbuf (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (push_v),
      .in_ready_o  (push_rdy),
      .in_data_i   ({addr_r[3:0], rx_r}),
      .out_valid_o (pop_v),
      .out_ready_i (pop_rdy),
      .out_data_o  (pop_data)
   );

   // The latch is frozen while a timed write owns it
   assign pop_rdy = !busy_r;
   assign wr_go   = stop_det && pend_r && (state_r == ees_pkg::ST_WDATA);
   assign wr_done = busy_r && (tmr_r == '0);

   always_ff @(posedge sys_clk_i)
   begin
      if (pop_v && pop_rdy)
         page_r[pop_data[11:8]] <= pop_data[7:0];
   end

   // Valid mask; a start outside a write cycle abandons a partial page
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         pvalid_r <= '0;
      else if (wr_done || (start_det && !busy_r))
         pvalid_r <= '0;
      else if (pop_v && pop_rdy)
         pvalid_r[pop_data[11:8]] <= 1'b1;
   end

   //-------------------------------------------------------------------
   // Self-timed nonvolatile write cycle
   //-------------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         busy_r     <= 1'b0;
         tmr_r      <= '0;
         row_r      <= ees_pkg::CNT_ZERO;
         cmd_lock_r <= 1'b0;
         standby_r  <= 1'b1;
      end
      else
      begin
         if (wr_go)
         begin
            busy_r     <= 1'b1;
            tmr_r      <= TW'(WR_CYCLES - 1);
            row_r      <= addr_r[7:4];
            cmd_lock_r <= lockcmd_r;
         end
         else if (wr_done)
            busy_r <= 1'b0;
         else if (busy_r)
            tmr_r <= tmr_r - 1'b1;
         standby_r <= (state_r == ees_pkg::ST_IDLE) && !busy_r;
      end
   end
   assign standby_o = standby_r;

   // Commit at the end of the cycle; protected bytes are just dropped
   always_ff @(posedge sys_clk_i)
   begin
      if (wr_done && cmd_lock_r && !wp_s)
         lock_r <= 1'b1;
      for (int i = 0; i < ees_pkg::PAGE_BYTES; i++)
      begin
         if (wr_done && !cmd_lock_r && pvalid_r[i] &&
             writable({row_r, 4'(i)}, wp_s, lock_r))
            mem_r[{row_r, 4'(i)}] <= page_r[i];
      end
   end

   //-------------------------------------------------------------------
   // Assertions
   //-------------------------------------------------------------------
   property p_busy_nack;
      @(posedge sys_clk_i) disable iff (rst_i)
      word_done && busy_r && state_r == ees_pkg::ST_DEV |=> !ack_r;
   endproperty
   a_busy_nack: assert property (p_busy_nack)
      else $error("address word acked during write cycle");

   property p_start;
      @(posedge sys_clk_i) disable iff (rst_i)
      start_det |=> state_r == ees_pkg::ST_DEV && cnt_r == 4'h0;
   endproperty
   a_start: assert property (p_start)
      else $error("start not followed by address phase");

   property p_stop;
      @(posedge sys_clk_i) disable iff (rst_i)
      stop_det && !start_det |=> state_r == ees_pkg::ST_IDLE && !ack_r;
   endproperty
   a_stop: assert property (p_stop)
      else $error("stop did not return to idle");

   property p_mismatch;
      @(posedge sys_clk_i) disable iff (rst_i)
      word_done && state_r == ees_pkg::ST_DEV && rx_r[3:1] != cs_s
      |=> !ack_r;
   endproperty
   a_mismatch: assert property (p_mismatch)
      else $error("acked a word with foreign strap address");

   property p_locked_nack;
      @(posedge sys_clk_i) disable iff (rst_i)
      word_done && state_r == ees_pkg::ST_DEV && is_lock && lock_r
      |=> !ack_r;
   endproperty
   a_locked_nack: assert property (p_locked_nack)
      else $error("lock control code acked after programming");

   property p_lock_sticky;
      @(posedge sys_clk_i) lock_r |=> lock_r;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky)
      else $error("lock cleared");

   property p_lock_needs_wp_low;
      @(posedge sys_clk_i) disable iff (rst_i)
      !lock_r ##1 lock_r |-> $past(!wp_s) && $past(wr_done);
   endproperty
   a_lock_needs_wp_low: assert property (p_lock_needs_wp_low)
      else $error("lock set without cycle end or with protect high");

   property p_page_wrap;
      @(posedge sys_clk_i) disable iff (rst_i)
      push_v && push_rdy && !start_det && !stop_det
      |=> addr_r[3:0] == $past(addr_r[3:0]) + 4'h1 &&
          addr_r[7:4] == $past(addr_r[7:4]);
   endproperty
   a_page_wrap: assert property (p_page_wrap)
      else $error("page write address not wrapping in page");

   property p_busy_hold;
      @(posedge sys_clk_i) disable iff (rst_i)
      wr_go |=> busy_r [*8];
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("write cycle ended too early");

   property p_open_drain;
      @(posedge sys_clk_i) disable iff (rst_i)
      ack_r |-> !sda_oe_n_o && !sda_o;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("ack not driven low");

endmodule

/* File: testbench/ees_bus_master.sv */
// Purpose : Two-wire bus master driving the EEPROM slave
// Assumes : SCL period of ten system clocks (80 ns)
// Notes   : A released SDA reads high through the pull-up
`timescale 1ns/100ps

module ees_bus_master (
   input  wire logic sys_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   //------------------
   // Bit level
   //------------------
   // Both lines start released
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end

   task automatic w(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   // Data moves only while SCL is low, sampled mid-high
   task automatic bitc(input logic b, output logic s);
      w(2);
      sda_o <= b;
      w(3);
      scl_o <= 1'b1;
      w(3);
      s = sda_i;
      w(2);
      scl_o <= 1'b0;
   endtask

   // Waits for an ack of the last bit to be let go first
   task automatic start;
      w(3);
      sda_o <= 1'b1;
      w(2);
      scl_o <= 1'b1;
      w(5);
      sda_o <= 1'b0;
      w(5);
      scl_o <= 1'b0;
   endtask

   task automatic stop;
      w(3);
      sda_o <= 1'b0;
      w(3);
      scl_o <= 1'b1;
      w(5);
      sda_o <= 1'b1;
      w(5);
   endtask

   // MSB first, ninth clock carries the ack
   task automatic tx(input logic [7:0] b, output logic nk);
      logic s;
      for (int i = 7; i >= 0; i--)
         bitc(b[i], s);
      bitc(1'b1, nk);
   endtask

   task automatic rx(input logic ak, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         bitc(1'b1, d[i]);
      bitc(ak, s);
   endtask
endmodule

/* File: testbench/tb.sv */
// Purpose : Self-checking bench of the EEPROM slave
// Assumes : Short write cycle of 200 clocks
// Notes   : wp only changes once a read has outwaited the cycle
`timescale 1ns/100ps

module tb;
   //------------------
   // Bench
   //------------------
   localparam logic [3:0] ARR = ees_pkg::CTRL_ARRAY;
   localparam logic [3:0] LCK = ees_pkg::CTRL_LOCK;
   logic        sys_clk;
   logic        rst;
   logic        scl;
   logic        m_sda;
   logic        s_sda;
   logic        s_oe_n;
   logic        stby;
   logic        wp;
   logic [2:0]  cs;
   logic [7:0]  mem [256];
   logic        lock = 1'b0;
   logic [31:0] rng = 32'h1e121fed;
   int          n_mismatch = 0;
   int          checked = 0;
   // Wired-and of both open-drain drivers
   wire         sda_w = m_sda & (s_oe_n | s_sda);

   ees_eeprom_slave #(.WR_CYCLES(200)) u_ees_eeprom_slave (
      .sys_clk_i(sys_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_w),
      .sda_o(s_sda), .sda_oe_n_o(s_oe_n), .chip_select_bit2_i(cs[2]),
      .chip_select_bit1_i(cs[1]), .chip_select_bit0_i(cs[0]),
      .wp_i(wp), .standby_o(stby));
   ees_bus_master mst (.sys_clk_i(sys_clk), .sda_i(sda_w),
      .scl_o(scl), .sda_o(m_sda));

   function automatic logic [7:0] rnd();
      rng = {rng[30:0], rng[31] ^ rng[21] ^ rng[1] ^ rng[0]};
      return rng[7:0];
   endfunction

   task automatic chk(input string nm, input logic [7:0] e, g);
      checked++;
      if (g !== e || $isunknown(g))
      begin
         n_mismatch++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask

   // One address word; an acked read takes the filler byte
   task automatic probe(input logic [7:0] dw, input logic en);
      logic       nk;
      logic [7:0] d;
      mst.start();
      mst.tx(dw, nk);
      chk("dev_nack", en, nk);
      if (nk === 1'b0 && dw[0])
         mst.rx(1'b1, d);
      mst.stop();
   endtask

   // Polls until the write address word is acked
   task automatic sel(input logic [3:0] c);
      logic nk;
      nk = 1'b1;
      for (int k = 0; k < 12 && nk !== 1'b0; k++)
      begin
         mst.start();
         mst.tx({c, cs, 1'b0}, nk);
      end
      chk("poll_ack", 1'b0, nk);
   endtask

   task automatic wr(input logic [3:0] c, input logic [7:0] a,
                     input logic [7:0] q[$]);
      logic       nk;
      logic [7:0] p;
      sel(c);
      mst.tx(a, nk);
      chk("addr_ack", 1'b0, nk);
      p = a;
      foreach (q[i])
      begin
         mst.tx(q[i], nk);
         chk("data_ack", 1'b0, nk);
         if (c == ARR && !wp && !(lock && !p[7]))
            mem[p] = q[i];
         p = {p[7:4], p[3:0] + 4'h1};
      end
      if (c == LCK && !wp)
         lock = 1'b1;
      mst.stop();
      #1;
      chk("standby", 1'b0, stby);
      probe({c, cs, 1'b0}, 1'b1);
   endtask

   task automatic rd(input logic [7:0] a, input int n);
      logic       nk;
      logic [7:0] d;
      sel(ARR);
      mst.tx(a, nk);
      mst.start();
      mst.tx({ARR, cs, 1'b1}, nk);
      chk("rd_ack", 1'b0, nk);
      for (int i = 0; i < n; i++)
      begin
         mst.rx(i == n - 1, d);
         chk("rd_data", mem[a + i], d);
      end
      mst.stop();
   endtask

   task automatic wrap_up;
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // 125 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // Hang guard, well past the expected run
   initial
   begin
      repeat (60000) @(posedge sys_clk);
      n_mismatch++;
      wrap_up();
   end

   // Main sequence; wp moves only after a read so no cycle is pending
   initial
   begin
      logic [7:0] q[$];
      logic       nk;
      rst = 1'b1;
      wp = 1'b0;
      cs = 3'h0;
      repeat (8) @(posedge sys_clk);
      cs <= rng[4:2];
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      #1;
      chk("standby", 1'b1, stby);
      mst.tx(8'hff, nk);
      chk("sda_idle", 1'b1, nk);
      probe({ARR, ~cs, 1'b0}, 1'b1);
      probe({LCK, cs, 1'b1}, 1'b0);
      q = {rnd()};
      wr(ARR, 8'h05, q);
      q = {rnd()};
      wr(ARR, 8'h06, q);
      q = {};
      repeat (18) q.push_back(rnd());
      wr(ARR, 8'h93, q);
      rd(8'h05, 1);
      rd(8'h90, 16);
      wp <= 1'b1;
      q = {rnd()};
      wr(ARR, 8'h05, q);
      wr(LCK, 8'h00, q);
      rd(8'h05, 1);
      probe({LCK, cs, 1'b1}, 1'b0);
      wp <= 1'b0;
      wr(LCK, 8'h00, q);
      rd(8'h90, 1);
      probe({LCK, cs, 1'b1}, 1'b1);
      probe({LCK, cs, 1'b0}, 1'b1);
      q = {rnd(), rnd()};
      wr(ARR, 8'h05, q);
      wr(ARR, 8'h9f, q);
      rd(8'h05, 2);
      rd(8'h90, 16);
      #1;
      chk("standby", 1'b1, stby);
      wrap_up();
   end
endmodule
